// ---- verilog/wcr_params.svh ----
// constants for the workspace context registers
`ifndef WCR_PARAMS_SVH
`define WCR_PARAMS_SVH

// reset values of the three internal registers
`define WCR_WP_RST      16'h0000
`define WCR_PC_RST      16'h0000
`define WCR_ST_RST      16'h0000

// workspace registers that receive the old context
`define WCR_LINK_WP     4'hD
`define WCR_LINK_PC     4'hE
`define WCR_LINK_ST     4'hF

// address steps in bytes
`define WCR_WORD_STEP   16'h0002
`define WCR_VEC_SHIFT   2

// status register field positions
`define WCR_ST_LGT      15
`define WCR_ST_AGT      14
`define WCR_ST_EQ       13
`define WCR_FLAGS_LSB   4
`define WCR_MASK_MSB    3

`endif

// ---- verilog/wcr_pkg.sv ----
// types of the workspace context registers
`default_nettype none
package wcr_pkg;

  typedef enum logic [3:0] {
    WCR_OP_NOP      = 4'h0,
    WCR_OP_LOAD_WP  = 4'h1,
    WCR_OP_LOAD_PC  = 4'h2,
    WCR_OP_LOAD_FLG = 4'h3,
    WCR_OP_LOAD_MSK = 4'h4,
    WCR_OP_FETCH    = 4'h5,
    WCR_OP_REG_RD   = 4'h6,
    WCR_OP_REG_WR   = 4'h7,
    WCR_OP_REG_RDB  = 4'h8,
    WCR_OP_REG_WRB  = 4'h9,
    WCR_OP_SWITCH   = 4'hA,
    WCR_OP_RETURN   = 4'hB
  } wcr_op_t;

  typedef enum logic [2:0] {
    WCR_S_IDLE  = 3'h0,
    WCR_S_READ  = 3'h1,
    WCR_S_WRITE = 3'h2,
    WCR_S_VEC   = 3'h3,
    WCR_S_SAVE  = 3'h4,
    WCR_S_REST  = 3'h5
  } wcr_state_t;

endpackage
`default_nettype wire

// ---- verilog/wcr_irq_gate.sv ----
// interrupt request synchroniser and priority gate
`timescale 1ns/1ps
`default_nettype none
module wcr_irq_gate (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_level,
  input  wire logic [3:0] mask,
  output logic            irq_ok,
  output logic [3:0]      irq_level_s
);
  logic       req_m_r;
  logic       req_s_r;
  logic [3:0] lvl_m_r;
  logic [3:0] lvl_s_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      lvl_m_r <= 4'hF;
      lvl_s_r <= 4'hF;
    end else begin
      req_m_r <= irq_req;
      req_s_r <= req_m_r;
      lvl_m_r <= irq_level;
      lvl_s_r <= lvl_m_r;
    end
  end

  // level 0 is highest; accept equal or higher priority than the mask
  assign irq_ok      = req_s_r && (lvl_s_r <= mask);
  assign irq_level_s = lvl_s_r;
endmodule // wcr_irq_gate
`default_nettype wire

// ---- verilog/wcr_context.sv ----
// workspace context registers: workspace base, next instruction pointer, status
// Operation
// - workspace base register locates a 16-word block used as general registers.
// - loading the workspace base makes the word there register 0.
// - no internal data registers; register access is a memory access off the base.
// - pointer advances on instruction fetch unless loaded by jump or context switch.
// - a context switch saves only base, pointer and status, never the register set.
// - status has data flags updated by data, and an interrupt mask field.
// - byte addressing over a 65,536 byte space.
// - memory is 32,768 sixteen-bit words; bytes are selected or merged internally.
// - context switch links the new workspace to the old one automatically.
// - old base, pointer and status go to registers 13, 14, 15 of new workspace.
// - maskable interrupt taken only when its level is equal or higher priority than the mask.
`timescale 1ns/1ps
`default_nettype none
`include "wcr_params.svh"
module wcr_context (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_op,
  input  wire logic [15:0] cmd_data,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  input  wire logic        irq_req,
  input  wire logic [3:0]  irq_level,
  output logic             irq_ack,
  output logic [15:0]      wp_out,
  output logic [15:0]      next_instr_pointer,
  output logic [15:0]      processor_status,
  output logic             mem_req,
  output logic             mem_we,
  output logic [14:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata
);
  wcr_pkg::wcr_state_t state_r;
  logic [1:0]          step_r;
  logic                rmw_r;
  logic                byte_r;
  logic                lo_r;
  logic [7:0]          bdata_r;
  logic [15:0]         vec_r;
  logic [15:0]         new_wp_r;
  logic [15:0]         new_pc_r;
  logic [15:0]         sv_wp_r;
  logic [15:0]         sv_pc_r;
  logic [15:0]         rs_wp_r;
  logic [15:0]         rs_pc_r;
  logic                irq_ok;
  logic [3:0]          irq_lvl;
  logic                take_cmd;
  logic                take_irq;
  logic                ack;
  logic                sw_done;
  logic                ret_done;
  logic                rd_done;
  wcr_pkg::wcr_op_t    op;

  // byte address of a workspace register; 16-bit sum wraps in the 64K space
  function automatic logic [15:0] reg_addr(input logic [15:0] base, input logic [3:0] n);
    reg_addr = base + {11'h000, n, 1'b0};
  endfunction

  // select the addressed byte of a word; even byte is the high half
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic lo);
    pick_byte = lo ? w[7:0] : w[15:8];
  endfunction

  // word address of a workspace register
  function automatic logic [14:0] reg_word(input logic [15:0] base, input logic [3:0] n);
    logic [15:0] a;
    a        = reg_addr(base, n);
    reg_word = a[15:1];
  endfunction

  assign op       = wcr_pkg::wcr_op_t'(cmd_op);
  assign take_cmd = cmd_ready && cmd_valid;
  assign take_irq = (state_r == wcr_pkg::WCR_S_IDLE) && !take_cmd && irq_ok;
  assign ack      = mem_req && mem_ack;
  assign sw_done  = (state_r == wcr_pkg::WCR_S_SAVE) && ack && (step_r == 2'h2);
  assign ret_done = (state_r == wcr_pkg::WCR_S_REST) && ack && (step_r == 2'h2);
  assign rd_done  = (state_r == wcr_pkg::WCR_S_READ) && ack && !rmw_r;

  wcr_irq_gate u_gate (
    .clk         (clk),
    .nrst        (nrst),
    .irq_req     (irq_req),
    .irq_level   (irq_level),
    .mask        (processor_status[`WCR_MASK_MSB:0]),
    .irq_ok      (irq_ok),
    .irq_level_s (irq_lvl)
  );

  // ***************************************************************
  // workspace base register
  // ***************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_out <= `WCR_WP_RST;
    end else if (take_cmd && op == wcr_pkg::WCR_OP_LOAD_WP) begin
      wp_out <= cmd_data;
    end else if (sw_done) begin
      wp_out <= new_wp_r;
    end else if (ret_done) begin
      wp_out <= rs_wp_r;
    end
  end

  // ***************************************************************
  // next instruction pointer
  // ***************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      next_instr_pointer <= `WCR_PC_RST;
    end else if (take_cmd && op == wcr_pkg::WCR_OP_LOAD_PC) begin
      next_instr_pointer <= cmd_data;
    end else if (take_cmd && op == wcr_pkg::WCR_OP_FETCH) begin
      next_instr_pointer <= next_instr_pointer + `WCR_WORD_STEP;
    end else if (sw_done) begin
      next_instr_pointer <= new_pc_r;
    end else if (ret_done) begin
      next_instr_pointer <= rs_pc_r;
    end
  end

  // ***************************************************************
  // status register: data flags and interrupt mask
  // ***************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      processor_status <= `WCR_ST_RST;
    end else if (take_cmd && op == wcr_pkg::WCR_OP_LOAD_FLG) begin
      processor_status[15:`WCR_FLAGS_LSB] <= cmd_data[15:`WCR_FLAGS_LSB];
    end else if (take_cmd && op == wcr_pkg::WCR_OP_LOAD_MSK) begin
      processor_status[`WCR_MASK_MSB:0] <= cmd_data[`WCR_MASK_MSB:0];
    end else if (rd_done && !byte_r) begin
      processor_status[`WCR_ST_LGT] <= (mem_rdata != 16'h0000);
      processor_status[`WCR_ST_AGT] <= !mem_rdata[15] && (mem_rdata != 16'h0000);
      processor_status[`WCR_ST_EQ]  <= (mem_rdata == 16'h0000);
    end else if (ret_done) begin
      processor_status <= mem_rdata;
    end
  end

  // ***************************************************************
  // sequencer and word memory port
  // ***************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= wcr_pkg::WCR_S_IDLE;
      step_r    <= 2'h0;
      rmw_r     <= 1'b0;
      byte_r    <= 1'b0;
      lo_r      <= 1'b0;
      bdata_r   <= 8'h00;
      vec_r     <= 16'h0000;
      new_wp_r  <= 16'h0000;
      new_pc_r  <= 16'h0000;
      sv_wp_r   <= 16'h0000;
      sv_pc_r   <= 16'h0000;
      rs_wp_r   <= 16'h0000;
      rs_pc_r   <= 16'h0000;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
      irq_ack   <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 15'h0000;
      mem_wdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      irq_ack   <= 1'b0;
      case (state_r)
        wcr_pkg::WCR_S_IDLE: begin
          cmd_ready <= 1'b1;
          if (take_cmd) begin
            rmw_r  <= (op == wcr_pkg::WCR_OP_REG_WRB);
            byte_r <= (op == wcr_pkg::WCR_OP_REG_RDB) || (op == wcr_pkg::WCR_OP_REG_WRB);
            lo_r   <= cmd_data[4];
            bdata_r <= cmd_wdata[7:0];
            mem_we <= 1'b0;
            case (op)
              wcr_pkg::WCR_OP_FETCH: begin
                mem_req   <= 1'b1;
                mem_addr  <= next_instr_pointer[15:1];
                cmd_ready <= 1'b0;
                state_r   <= wcr_pkg::WCR_S_READ;
              end
              wcr_pkg::WCR_OP_REG_RD, wcr_pkg::WCR_OP_REG_RDB,
              wcr_pkg::WCR_OP_REG_WRB: begin
                mem_req   <= 1'b1;
                mem_addr  <= reg_word(wp_out, cmd_data[3:0]);
                cmd_ready <= 1'b0;
                state_r   <= wcr_pkg::WCR_S_READ;
              end
              wcr_pkg::WCR_OP_REG_WR: begin
                mem_req   <= 1'b1;
                mem_we    <= 1'b1;
                mem_addr  <= reg_word(wp_out, cmd_data[3:0]);
                mem_wdata <= cmd_wdata;
                cmd_ready <= 1'b0;
                state_r   <= wcr_pkg::WCR_S_WRITE;
              end
              wcr_pkg::WCR_OP_SWITCH: begin
                vec_r     <= cmd_data;
                sv_wp_r   <= wp_out;
                sv_pc_r   <= next_instr_pointer;
                mem_req   <= 1'b1;
                mem_addr  <= cmd_data[15:1];
                step_r    <= 2'h0;
                cmd_ready <= 1'b0;
                state_r   <= wcr_pkg::WCR_S_VEC;
              end
              wcr_pkg::WCR_OP_RETURN: begin
                mem_req   <= 1'b1;
                mem_addr  <= reg_word(wp_out, `WCR_LINK_WP);
                step_r    <= 2'h0;
                cmd_ready <= 1'b0;
                state_r   <= wcr_pkg::WCR_S_REST;
              end
              default: begin
                rsp_valid <= 1'b0;
              end
            endcase
          end else if (take_irq) begin
            // vector pair of the level: base address is level times four
            vec_r     <= {10'h000, irq_lvl, 2'h0};
            sv_wp_r   <= wp_out;
            sv_pc_r   <= next_instr_pointer;
            irq_ack   <= 1'b1;
            mem_req   <= 1'b1;
            mem_we    <= 1'b0;
            mem_addr  <= {10'h000, irq_lvl, 1'b0};
            step_r    <= 2'h0;
            cmd_ready <= 1'b0;
            state_r   <= wcr_pkg::WCR_S_VEC;
          end
        end
        wcr_pkg::WCR_S_READ: begin
          if (ack) begin
            if (rmw_r) begin
              mem_we    <= 1'b1;
              mem_wdata <= lo_r ? {mem_rdata[15:8], bdata_r} : {bdata_r, mem_rdata[7:0]};
              state_r   <= wcr_pkg::WCR_S_WRITE;
            end else begin
              mem_req   <= 1'b0;
              rsp_valid <= 1'b1;
              rsp_data  <= byte_r ? {8'h00, pick_byte(mem_rdata, lo_r)} : mem_rdata;
              cmd_ready <= 1'b1;
              state_r   <= wcr_pkg::WCR_S_IDLE;
            end
          end
        end
        wcr_pkg::WCR_S_WRITE: begin
          if (ack) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_data  <= mem_wdata;
            cmd_ready <= 1'b1;
            state_r   <= wcr_pkg::WCR_S_IDLE;
          end
        end
        wcr_pkg::WCR_S_VEC: begin
          if (ack && step_r == 2'h0) begin
            new_wp_r <= mem_rdata;
            mem_addr <= vec_r[15:1] + 15'h0001;
            step_r   <= 2'h1;
          end else if (ack) begin
            new_pc_r  <= mem_rdata;
            mem_we    <= 1'b1;
            mem_addr  <= reg_word(new_wp_r, `WCR_LINK_WP);
            mem_wdata <= sv_wp_r;
            step_r    <= 2'h0;
            state_r   <= wcr_pkg::WCR_S_SAVE;
          end
        end
        wcr_pkg::WCR_S_SAVE: begin
          // only three words are stored; the register set stays in place
          if (ack && step_r == 2'h2) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_data  <= new_wp_r;
            cmd_ready <= 1'b1;
            state_r   <= wcr_pkg::WCR_S_IDLE;
          end else if (ack) begin
            mem_addr  <= reg_word(new_wp_r, (step_r == 2'h0) ? `WCR_LINK_PC : `WCR_LINK_ST);
            mem_wdata <= (step_r == 2'h0) ? sv_pc_r : processor_status;
            step_r    <= step_r + 2'h1;
          end
        end
        wcr_pkg::WCR_S_REST: begin
          if (ack && step_r == 2'h2) begin
            mem_req   <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_data  <= rs_wp_r;
            cmd_ready <= 1'b1;
            state_r   <= wcr_pkg::WCR_S_IDLE;
          end else if (ack) begin
            if (step_r == 2'h0) begin
              rs_wp_r <= mem_rdata;
            end else begin
              rs_pc_r <= mem_rdata;
            end
            mem_addr <= reg_word(wp_out, (step_r == 2'h0) ? `WCR_LINK_PC : `WCR_LINK_ST);
            step_r   <= step_r + 2'h1;
          end
        end
        default: begin
          mem_req <= 1'b0;
          state_r <= wcr_pkg::WCR_S_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_wp_load_value: assert property (take_cmd && op == wcr_pkg::WCR_OP_LOAD_WP
    |=> wp_out == $past(cmd_data)) else $error("base not loaded");
  a_reg_word_addr: assert property (take_cmd && op == wcr_pkg::WCR_OP_REG_RD
    |=> mem_req && !mem_we && mem_addr == reg_word(wp_out, $past(cmd_data[3:0])))
    else $error("register address wrong");
  a_fetch_advance: assert property (take_cmd && op == wcr_pkg::WCR_OP_FETCH
    |=> next_instr_pointer == $past(next_instr_pointer) + 16'h0002)
    else $error("pointer not advanced by two");
  a_switch_commit: assert property (sw_done
    |=> wp_out == $past(new_wp_r) && next_instr_pointer == $past(new_pc_r))
    else $error("context not committed");
  a_link_old_base: assert property ($rose(state_r == wcr_pkg::WCR_S_SAVE)
    |-> mem_we && mem_wdata == sv_wp_r && mem_addr == reg_word(new_wp_r, `WCR_LINK_WP))
    else $error("old base not linked to register 13");
  a_save_only_three: assert property (state_r == wcr_pkg::WCR_S_SAVE
    |-> mem_req && mem_we && step_r != 2'h3)
    else $error("save sequence malformed");
  a_irq_priority: assert property (irq_ack
    |-> $past(irq_lvl) <= $past(processor_status[3:0]))
    else $error("interrupt below mask taken");
  a_byte_merge: assert property (state_r == wcr_pkg::WCR_S_READ && rmw_r && ack
    |=> mem_we && mem_addr == $past(mem_addr) && state_r == wcr_pkg::WCR_S_WRITE)
    else $error("byte write not merged into word");
  a_flag_equal: assert property (rd_done && !byte_r
    |=> processor_status[13] == ($past(mem_rdata) == 16'h0000))
    else $error("equal flag wrong");
  a_irq_vector: assert property (irq_ack
    |-> mem_req && !mem_we && mem_addr == {10'h000, $past(irq_lvl), 1'b0})
    else $error("vector address wrong");

  c_irq_switch: cover property (irq_ack ##[1:40] sw_done);
  c_cmd_switch: cover property (take_cmd && op == wcr_pkg::WCR_OP_SWITCH ##[1:40] sw_done);
  c_return: cover property (ret_done);
  c_byte_write: cover property (state_r == wcr_pkg::WCR_S_READ && rmw_r && ack);
endmodule // wcr_context
`default_nettype wire

// ---- bench/wcr_mem_model.sv ----
// word-wide program and data memory answering the context block
`timescale 1ns/1ps
`default_nettype none
module wcr_mem_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  delay,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [14:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] mem [0:32767];
  logic [3:0]  wait_r;
  // ****************************************
  // answer after delay idle cycles
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_ack   <= 1'b0;
      wait_r    <= 4'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && wait_r >= delay) begin
      mem_ack   <= 1'b1;
      wait_r    <= 4'h0;
      mem_rdata <= mem[mem_addr];
    end else begin
      mem_ack   <= 1'b0;
      wait_r    <= (mem_req && !mem_ack) ? wait_r + 4'h1 : 4'h0;
      // no stale data outside the answer cycle
      mem_rdata <= ~mem_rdata;
    end
  end

  // storage is also preloaded by the bench, so it lives in a plain process
  always @(posedge clk) begin
    if (nrst && mem_req && !mem_ack && wait_r >= delay && mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule // wcr_mem_model
`default_nettype wire

// ---- bench/test_wcr_context.sv ----
// self-checking bench for the workspace context registers
`timescale 1ns/1ps
`default_nettype none
module test_wcr_context;
  logic        clk, nrst, cmd_valid, cmd_ready, rsp_valid, irq_req, irq_ack;
  logic        mem_req, mem_we, mem_ack;
  logic [3:0]  cmd_op, irq_level, delay;
  logic [14:0] mem_addr;
  logic [15:0] cmd_data, cmd_wdata, rsp_data, wp_out, next_instr_pointer, processor_status;
  logic [15:0] mem_wdata, mem_rdata, r;
  int          fail_count, checked;
  logic [15:0] acc_q[$];

  wcr_context wcr_context_inst (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .irq_req(irq_req), .irq_level(irq_level), .irq_ack(irq_ack), .wp_out(wp_out),
    .next_instr_pointer(next_instr_pointer), .processor_status(processor_status),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );
  wcr_mem_model wcr_mem_model_inst (
    .clk(clk), .nrst(nrst), .delay(delay), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // log every finished memory access as {we, word address}
  always @(negedge clk) begin
    if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      acc_q.push_back({mem_we, mem_addr});
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic close_out();
    $display("TB: checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // which: 0 ready, 1 response, 2 interrupt accepted
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        fail_count++;
        close_out();
      end
    end while (!((which == 0 && cmd_ready === 1'b1) || (which == 1 && rsp_valid === 1'b1)
                 || (which == 2 && irq_ack === 1'b1)));
  endtask

  task automatic do_cmd(input wcr_pkg::wcr_op_t op, input logic [15:0] d, input logic [15:0] w);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_data  <= d;
    cmd_wdata <= w;
    wait_for(0);
    @(posedge clk);
    cmd_valid <= 1'b0;
    acc_q.delete();
    if (op >= wcr_pkg::WCR_OP_FETCH) begin
      wait_for(1);
      r = rsp_data;
    end else begin
      @(negedge clk);
    end
  endtask

  task automatic poke(input logic [14:0] a, input logic [15:0] v);
    wcr_mem_model_inst.mem[a] = v;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    @(negedge clk);
    check_word({15'h0000, cmd_ready}, 16'h0000);
    check_word(wp_out, 16'h0000);
    check_word(next_instr_pointer, 16'h0000);
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check_word({15'h0000, cmd_ready}, 16'h0001);
  endtask

  task automatic t_reg_access();
    logic [15:0] wps [3] = '{16'h0100, 16'h0100, 16'hFFE0};
    logic [15:0] ns [3]  = '{16'h0000, 16'h0005, 16'h000F};
    logic [15:0] a;
    for (int i = 0; i < 3; i++) begin
      a = wps[i] + 16'h0002 * ns[i];
      poke(a[15:1], 16'hA500 + 16'(i));
      do_cmd(wcr_pkg::WCR_OP_LOAD_WP, wps[i], 16'h0000);
      check_word(wp_out, wps[i]);
      do_cmd(wcr_pkg::WCR_OP_REG_RD, ns[i], 16'h0000);
      check_word(r, 16'hA500 + 16'(i));
      check_word(acc_q[0], {1'b0, a[15:1]});
      check_word(16'(acc_q.size()), 16'h0001);
    end
    do_cmd(wcr_pkg::WCR_OP_REG_WR, 16'h000F, 16'h1234);
    check_word(wcr_mem_model_inst.mem[15'h7FFF], 16'h1234);
    check_word(acc_q[0], 16'hFFFF);
  endtask

  task automatic t_status();
    logic [15:0] vals [3] = '{16'h0000, 16'h8000, 16'h0001};
    logic [2:0]  flg [3]  = '{3'b001, 3'b100, 3'b110};
    do_cmd(wcr_pkg::WCR_OP_LOAD_MSK, 16'h000A, 16'h0000);
    check_word({12'h000, processor_status[3:0]}, 16'h000A);
    do_cmd(wcr_pkg::WCR_OP_LOAD_FLG, 16'h5A50, 16'h0000);
    check_word(processor_status, 16'h5A5A);
    for (int i = 0; i < 3; i++) begin
      poke(15'h7FF1, vals[i]);
      do_cmd(wcr_pkg::WCR_OP_REG_RD, 16'h0001, 16'h0000);
      check_word({13'h0000, processor_status[15:13]}, {13'h0000, flg[i]});
      check_word({12'h000, processor_status[3:0]}, 16'h000A);
    end
  endtask

  task automatic t_bytes();
    do_cmd(wcr_pkg::WCR_OP_LOAD_WP, 16'h0200, 16'h0000);
    poke(15'h0103, 16'hABCD);
    do_cmd(wcr_pkg::WCR_OP_REG_RDB, 16'h0003, 16'h0000);
    check_word(r, 16'h00AB);
    do_cmd(wcr_pkg::WCR_OP_REG_RDB, 16'h0013, 16'h0000);
    check_word(r, 16'h00CD);
    do_cmd(wcr_pkg::WCR_OP_REG_WRB, 16'h0013, 16'h0012);
    check_word(wcr_mem_model_inst.mem[15'h0103], 16'hAB12);
    do_cmd(wcr_pkg::WCR_OP_REG_WRB, 16'h0003, 16'h0034);
    check_word(wcr_mem_model_inst.mem[15'h0103], 16'h3412);
  endtask

  task automatic t_fetch();
    delay = 4'h3;
    poke(15'h0200, 16'h1111);
    poke(15'h0201, 16'h2222);
    do_cmd(wcr_pkg::WCR_OP_LOAD_PC, 16'h0400, 16'h0000);
    do_cmd(wcr_pkg::WCR_OP_FETCH, 16'h0000, 16'h0000);
    check_word(r, 16'h1111);
    do_cmd(wcr_pkg::WCR_OP_FETCH, 16'h0000, 16'h0000);
    check_word(r, 16'h2222);
    check_word(next_instr_pointer, 16'h0404);
  endtask

  task automatic t_switch();
    logic [15:0] exp_acc [5] = '{16'h0020, 16'h0021, 16'h840D, 16'h840E, 16'h840F};
    delay = 4'h2;
    do_cmd(wcr_pkg::WCR_OP_LOAD_WP, 16'h0300, 16'h0000);
    do_cmd(wcr_pkg::WCR_OP_LOAD_PC, 16'h0500, 16'h0000);
    do_cmd(wcr_pkg::WCR_OP_LOAD_FLG, 16'h2460, 16'h0000);
    do_cmd(wcr_pkg::WCR_OP_LOAD_MSK, 16'h0003, 16'h0000);
    poke(15'h0020, 16'h0800);
    poke(15'h0021, 16'h0600);
    do_cmd(wcr_pkg::WCR_OP_SWITCH, 16'h0040, 16'h0000);
    check_word(r, 16'h0800);
    check_word(wp_out, 16'h0800);
    check_word(next_instr_pointer, 16'h0600);
    check_word(wcr_mem_model_inst.mem[15'h040D], 16'h0300);
    check_word(wcr_mem_model_inst.mem[15'h040E], 16'h0500);
    check_word(wcr_mem_model_inst.mem[15'h040F], 16'h2463);
    check_word(16'(acc_q.size()), 16'h0005);
    for (int i = 0; i < 5; i++) check_word(acc_q[i], exp_acc[i]);
    delay = 4'h0;
    do_cmd(wcr_pkg::WCR_OP_RETURN, 16'h0000, 16'h0000);
    check_word(wp_out, 16'h0300);
    check_word(next_instr_pointer, 16'h0500);
    check_word(processor_status, 16'h2463);
    check_word(acc_q[0], 16'h040D);
  endtask

  task automatic t_irq();
    poke(15'h0006, 16'h0900);
    poke(15'h0007, 16'h0700);
    @(posedge clk);
    irq_level <= 4'h4;
    irq_req   <= 1'b1;
    repeat (12) begin
      @(negedge clk);
      check_word({15'h0000, irq_ack}, 16'h0000);
    end
    @(posedge clk);
    irq_level <= 4'h3;
    wait_for(2);
    @(posedge clk);
    irq_req <= 1'b0;
    @(negedge clk);
    wait_for(0);
    check_word(wp_out, 16'h0900);
    check_word(next_instr_pointer, 16'h0700);
    check_word(wcr_mem_model_inst.mem[15'h048D], 16'h0300);
  endtask

  initial begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_data = 16'h0000;
    cmd_wdata = 16'h0000;
    irq_req = 1'b0;
    irq_level = 4'hF;
    delay = 4'h0;
    fail_count = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    t_reset();
    t_reg_access();
    t_status();
    t_bytes();
    t_fetch();
    t_switch();
    t_irq();
    close_out();
  end

  initial begin
    #2000000;
    fail_count++;
    close_out();
  end
endmodule // test_wcr_context
`default_nettype wire
